// *** rtl/hpsd_pkg.sv ***
// How it works
// - separate-strobe style: fetch_enable low is the host's read enable
// - direction-strobe style: direction_select tells reads from writes
// - separate-strobe multiplexed bus: addr_latch_strobe marks address phase, address captured
// - direction-strobe multiplexed bus: addr_strobe_low low marks address phase, address captured
// - serial mode: host bit clock shifts serial_in_line in, serial_out_line out
// - accesses are accepted only while device_select_n is low
// - hardware mode: jitter attenuator in tx path low, rx path high, off open
// - parallel host: bus_style_select low direction-strobe, high separate-strobe
// - hardware unipolar: line_code_select low HDB3, high AMI, all eight channels
// - driver_output_enable low tri-states every transmit driver, rest keeps running
// - host mode: per-channel disable bits at register 12h tri-state drivers
// - clock recovery: edge select high rails on falling, serial out rising
// - data recovery: edge select sets rail output polarity high or low
// - parallel host: mux select high multiplexed bus, low separate buses
// - serial_out_line high impedance during serial writes and after each cycle
package hpsd_pkg;
  localparam int HPSD_AW = 5;
  localparam int HPSD_DW = 8;
  localparam int HPSD_CH = 8;
  localparam logic [4:0] HPSD_ODIS_ADDR = 5'h12;
  // wishbone register byte offsets
  localparam logic [7:0] HPSD_WB_CTRL = 8'h00;
  localparam logic [7:0] HPSD_WB_STAT = 8'h04;
  localparam logic [7:0] HPSD_WB_ODIS = 8'h08;
  localparam logic [7:0] HPSD_WB_LAST = 8'h0C;
  localparam logic [0:0] HPSD_CTRL_RST = 1'h1;
  localparam int HPSD_CTRL_EN_BIT = 0;
  // serial frame: rw, 5 address bits, 2 pad, 8 data bits, msb first
  localparam logic [4:0] HPSD_SER_HDR_DONE = 5'h05;
  localparam logic [4:0] HPSD_SER_DATA_START = 5'h08;
  localparam logic [4:0] HPSD_SER_LAST = 5'h0F;
  localparam logic [4:0] HPSD_SER_LEN = 5'h10;
  localparam logic [4:0] HPSD_SER_FALL_BASE = 5'h0F;
  localparam logic [4:0] HPSD_SER_RISE_BASE = 5'h0E;
  localparam int HPSD_SER_RW_BIT = 7;
  localparam int HPSD_PIN_W = 30;
endpackage : hpsd_pkg

// *** rtl/hpsd_regmem.sv ***
`timescale 1ns/1ps
module hpsd_regmem
  import hpsd_pkg::*;
#(
  parameter int AW = HPSD_AW,
  parameter int DW = HPSD_DW
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '0;
    end
    else if (ce_i)
    begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : hpsd_regmem

// *** rtl/hpsd_top.sv ***
`timescale 1ns/1ps
module hpsd_top
  import hpsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mode straps and control pins
  input wire logic host_mode_i,
  input wire logic serial_mode_i,
  input wire logic cdr_mode_i,
  input wire logic unipolar_i,
  input wire logic device_select_n_i,
  input wire logic fetch_enable_i,
  input wire logic direction_select_i,
  input wire logic transfer_strobe_i,
  input wire logic addr_latch_strobe_i,
  input wire logic addr_strobe_low_n_i,
  input wire logic bus_mux_select_i,
  input wire logic bus_style_select_i,
  input wire logic line_code_select_i,
  input wire logic driver_output_enable_i,
  input wire logic recovered_edge_select_i,
  input wire logic jitter_path_select_i,
  input wire logic jitter_path_open_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe_o,
  // serial port on the host's bit clock
  input wire logic serial_bit_clock_i,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_oe_o,
  // receive rails from the recovery logic (same clock)
  input wire logic rx_pos_raw_i,
  input wire logic rx_neg_raw_i,
  output logic rx_positive_rail_o,
  output logic rx_negative_rail_o,
  // decoded straps
  output logic ja_tx_path_o,
  output logic ja_rx_path_o,
  output logic hdb3_en_o,
  output logic ami_en_o,
  output logic [HPSD_CH-1:0] tx_hiz_o,
  output logic rail_on_fall_o,
  output logic sdo_on_rise_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [HPSD_PIN_W-1:0] pin_raw;
  logic [HPSD_PIN_W-1:0] pin_s1_r;
  logic [HPSD_PIN_W-1:0] pin_s2_r;
  logic [HPSD_PIN_W-1:0] pin_s3_r;

  assign pin_raw = {ad_i, addr_i, jitter_path_open_i, jitter_path_select_i,
                    recovered_edge_select_i, driver_output_enable_i, line_code_select_i,
                    bus_style_select_i, bus_mux_select_i, addr_strobe_low_n_i,
                    addr_latch_strobe_i, transfer_strobe_i, direction_select_i,
                    fetch_enable_i, device_select_n_i, unipolar_i, cdr_mode_i,
                    serial_mode_i, host_mode_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end
    else if (ce_i)
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  wire host_s = pin_s2_r[0];
  wire serial_s = pin_s2_r[1];
  wire cdr_s = pin_s2_r[2];
  wire uni_s = pin_s2_r[3];
  wire cs_n_s = pin_s2_r[4];
  wire fetch_s = pin_s2_r[5];
  wire dir_s = pin_s2_r[6];
  wire ts_s = pin_s2_r[7];
  wire ts_p = pin_s3_r[7];
  wire ale_s = pin_s2_r[8];
  wire ale_p = pin_s3_r[8];
  wire as_n_s = pin_s2_r[9];
  wire as_n_p = pin_s3_r[9];
  wire mux_s = pin_s2_r[10];
  wire sep_s = pin_s2_r[11];
  wire code_s = pin_s2_r[12];
  wire doe_s = pin_s2_r[13];
  wire esel_s = pin_s2_r[14];
  wire jsel_s = pin_s2_r[15];
  wire jopen_s = pin_s2_r[16];
  wire [4:0] addr_s = pin_s2_r[21:17];
  wire [7:0] ad_s = pin_s2_r[29:22];
  wire cs_p = pin_s3_r[4];

  // ****************************************
  // wishbone registers
  // ****************************************
  logic ctrl_en_r;
  logic [7:0] odis_r;
  logic [13:0] last_r;
  logic wb_req;
  logic wb_wr;
  logic [31:0] wb_rd;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_rd = (wb_adr_i == HPSD_WB_CTRL) ? {31'h0, ctrl_en_r} :
                 (wb_adr_i == HPSD_WB_STAT) ? {24'h0, doe_s, esel_s, cdr_s, uni_s,
                                               sep_s, mux_s, serial_s, host_s} :
                 (wb_adr_i == HPSD_WB_ODIS) ? {24'h0, odis_r} :
                 (wb_adr_i == HPSD_WB_LAST) ? {18'h0, last_r} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      ctrl_en_r <= HPSD_CTRL_RST;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_rd;
      if (wb_wr && wb_adr_i == HPSD_WB_CTRL)
      begin
        ctrl_en_r <= wb_dat_i[HPSD_CTRL_EN_BIT];
      end
    end
  end

  // ****************************************
  // parallel host port
  // ****************************************
  logic par_mode;
  logic rd_active;
  logic par_we;
  logic lat_evt;
  logic [4:0] addr_lat_r;
  logic [4:0] addr_cur;

  assign par_mode = host_s && !serial_s && ctrl_en_r;
  assign rd_active = par_mode && !cs_n_s && (sep_s ? !fetch_s : (!ts_s && dir_s));
  // write ends on strobe release while selected
  assign par_we = par_mode && !cs_n_s && !cs_p && ts_s && !ts_p && (sep_s || !dir_s);
  // address phase edge per style on the multiplexed bus
  assign lat_evt = par_mode && !cs_n_s && mux_s &&
                   (sep_s ? (!ale_s && ale_p) : (as_n_s && !as_n_p));
  assign addr_cur = mux_s ? addr_lat_r : addr_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_lat_r <= '0;
    end
    else if (ce_i && lat_evt)
    begin
      addr_lat_r <= ad_s[4:0];
    end
  end

  // ****************************************
  // serial port, bit clock domain
  // ****************************************
  logic [4:0] bit_cnt_r;
  logic [7:0] hdr_r;
  logic [7:0] sdat_r;
  logic [4:0] srd_addr_r;
  logic [4:0] swr_addr_r;
  logic [7:0] swr_data_r;
  logic srd_tgl_r;
  logic swr_tgl_r;
  logic esel_l1_r;
  logic esel_l2_r;
  logic sdo_f_r;
  logic sdo_r_r;
  logic oe_f_r;
  logic oe_r_r;
  logic [7:0] srd_hold_r;
  logic [4:0] idx_f;
  logic [4:0] idx_r;
  logic drive_f;
  logic drive_r;
  logic srd_go;
  logic swr_go;

  // frame counter cleared by the select pin itself
  always_ff @(posedge serial_bit_clock_i or posedge device_select_n_i)
  begin
    if (device_select_n_i)
    begin
      bit_cnt_r <= '0;
    end
    else if (bit_cnt_r != HPSD_SER_LEN)
    begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  assign srd_go = !device_select_n_i && bit_cnt_r == HPSD_SER_HDR_DONE && hdr_r[4];
  assign swr_go = !device_select_n_i && bit_cnt_r == HPSD_SER_LAST && !hdr_r[HPSD_SER_RW_BIT];

  // shift in on the rising bit clock
  always_ff @(posedge serial_bit_clock_i)
  begin
    if (bit_cnt_r < HPSD_SER_DATA_START)
    begin
      hdr_r <= {hdr_r[6:0], serial_in_line_i};
    end
    else if (bit_cnt_r != HPSD_SER_LEN)
    begin
      sdat_r <= {sdat_r[6:0], serial_in_line_i};
    end
    if (srd_go)
    begin
      srd_addr_r <= {hdr_r[3:0], serial_in_line_i};
    end
    if (swr_go)
    begin
      swr_addr_r <= hdr_r[6:2];
      swr_data_r <= {sdat_r[6:0], serial_in_line_i};
    end
    esel_l1_r <= recovered_edge_select_i;
    esel_l2_r <= esel_l1_r;
  end

  // toggles start equal, so nothing crosses before the first frame
  always_ff @(posedge serial_bit_clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      srd_tgl_r <= 1'b0;
      swr_tgl_r <= 1'b0;
    end
    else
    begin
      srd_tgl_r <= srd_tgl_r ^ srd_go;
      swr_tgl_r <= swr_tgl_r ^ swr_go;
    end
  end

  // read byte is held steady long before the first data bit is shifted out
  assign idx_f = HPSD_SER_FALL_BASE - bit_cnt_r;
  assign idx_r = HPSD_SER_RISE_BASE - bit_cnt_r;
  // drive only during the data half of a read frame
  assign drive_f = hdr_r[HPSD_SER_RW_BIT] && bit_cnt_r >= HPSD_SER_DATA_START &&
                   bit_cnt_r != HPSD_SER_LEN;
  // rw bit is one place short of the top when the first data bit is launched
  assign drive_r = ((bit_cnt_r == HPSD_SER_DATA_START - 5'h01) ? hdr_r[6] :
                    hdr_r[HPSD_SER_RW_BIT]) &&
                   bit_cnt_r >= HPSD_SER_LAST - 5'h08 && bit_cnt_r < HPSD_SER_LAST;

  // edge select high: update on falling, valid on rising
  always_ff @(negedge serial_bit_clock_i or posedge device_select_n_i)
  begin
    if (device_select_n_i)
    begin
      sdo_f_r <= 1'b0;
      oe_f_r <= 1'b0;
    end
    else
    begin
      sdo_f_r <= srd_hold_r[idx_f[2:0]];
      oe_f_r <= drive_f;
    end
  end

  // edge select low: update on rising, valid on falling
  always_ff @(posedge serial_bit_clock_i or posedge device_select_n_i)
  begin
    if (device_select_n_i)
    begin
      sdo_r_r <= 1'b0;
      oe_r_r <= 1'b0;
    end
    else
    begin
      sdo_r_r <= srd_hold_r[idx_r[2:0]];
      oe_r_r <= drive_r;
    end
  end

  // pick the flop for the selected edge
  assign serial_out_line_o = esel_l2_r ? sdo_f_r : sdo_r_r;
  assign serial_out_oe_o = esel_l2_r ? oe_f_r : oe_r_r;

  // ****************************************
  // crossing into the system clock
  // ****************************************
  logic [2:0] srd_sync_r;
  logic [2:0] swr_sync_r;
  logic srd_pend_r;
  logic srd_cap_r;
  logic ser_on;
  logic ser_we;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [4:0] mem_raddr;
  logic [7:0] mem_rdata;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srd_sync_r <= '0;
      swr_sync_r <= '0;
      srd_pend_r <= 1'b0;
      srd_cap_r <= 1'b0;
      srd_hold_r <= '0;
    end
    else if (ce_i)
    begin
      srd_sync_r <= {srd_sync_r[1:0], srd_tgl_r};
      swr_sync_r <= {swr_sync_r[1:0], swr_tgl_r};
      srd_pend_r <= ser_on && (srd_sync_r[2] != srd_sync_r[1]);
      srd_cap_r <= srd_pend_r;
      if (srd_cap_r)
      begin
        srd_hold_r <= mem_rdata;
      end
    end
  end

  assign ser_on = host_s && serial_s && ctrl_en_r;
  assign ser_we = ser_on && (swr_sync_r[2] != swr_sync_r[1]);
  assign mem_we = ser_we || par_we;
  assign mem_waddr = ser_we ? swr_addr_r : addr_cur;
  assign mem_wdata = ser_we ? swr_data_r : ad_s;
  assign mem_raddr = srd_pend_r ? srd_addr_r : addr_cur;

  hpsd_regmem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  // ****************************************
  // bus drive, output disable and straps
  // ****************************************
  logic ja_tx_nxt;
  logic ja_rx_nxt;
  logic [7:0] hiz_nxt;

  assign ja_tx_nxt = !host_s && !jopen_s && !jsel_s;
  assign ja_rx_nxt = !host_s && !jopen_s && jsel_s;
  assign hiz_nxt = !doe_s ? 8'hFF : (host_s ? odis_r : 8'h00);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ad_o <= '0;
      ad_oe_o <= 1'b0;
      odis_r <= '0;
      last_r <= '0;
      ja_tx_path_o <= 1'b0;
      ja_rx_path_o <= 1'b0;
      hdb3_en_o <= 1'b0;
      ami_en_o <= 1'b0;
      tx_hiz_o <= 8'hFF;
      rail_on_fall_o <= 1'b0;
      sdo_on_rise_o <= 1'b0;
      rx_positive_rail_o <= 1'b0;
      rx_negative_rail_o <= 1'b0;
    end
    else if (ce_i)
    begin
      ad_o <= mem_rdata;
      // drive the data bus only on a selected read
      ad_oe_o <= rd_active;
      // mirror of the output disable register
      if (mem_we && mem_waddr == HPSD_ODIS_ADDR)
      begin
        odis_r <= mem_wdata;
      end
      if (mem_we)
      begin
        last_r <= {ser_we, mem_waddr, mem_wdata};
      end
      ja_tx_path_o <= ja_tx_nxt;
      ja_rx_path_o <= ja_rx_nxt;
      // line code select in hardware unipolar mode
      hdb3_en_o <= !host_s && uni_s && !code_s;
      ami_en_o <= !host_s && uni_s && code_s;
      tx_hiz_o <= hiz_nxt;
      // edge indications: rail edge in clock recovery mode only, serial out edge in every mode
      rail_on_fall_o <= cdr_s && esel_s;
      sdo_on_rise_o <= esel_s;
      // rail polarity in data recovery mode
      rx_positive_rail_o <= (cdr_s || esel_s) ? rx_pos_raw_i : !rx_pos_raw_i;
      rx_negative_rail_o <= (cdr_s || esel_s) ? rx_neg_raw_i : !rx_neg_raw_i;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence ds_write_end;
    ce_i && par_mode && !sep_s && !dir_s && !cs_n_s && !cs_p && ts_s && !ts_p;
  endsequence

  chk_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ds_write_end |=> $past(mem_we) && (!ce_i || !ad_oe_o))
    else $error("direction-strobe write not taken");

  chk_read_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_active |=> ad_oe_o)
    else $error("read did not drive data bus");

  chk_deselect_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_n_s |-> !par_we && !rd_active && !lat_evt)
    else $error("activity while deselected");

  chk_addr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && lat_evt |=> addr_lat_r == $past(ad_s[4:0]))
    else $error("address not captured");

  chk_jitter_place: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !host_s && !jopen_s |=> ja_tx_path_o == !$past(jsel_s) && !ja_rx_path_o == ja_tx_path_o)
    else $error("jitter placement wrong");

  chk_line_code: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !host_s && uni_s |=> hdb3_en_o == !$past(code_s) && ami_en_o == $past(code_s))
    else $error("line code select wrong");

  chk_driver_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !doe_s |=> tx_hiz_o == 8'hFF)
    else $error("drivers not tri-stated");

  chk_odis_channel: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && host_s && doe_s |=> tx_hiz_o == $past(odis_r))
    else $error("per-channel disable not applied");

  chk_rail_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !cdr_s && !esel_s |=> rx_positive_rail_o == !$past(rx_pos_raw_i))
    else $error("rail polarity wrong");

  chk_sdo_write_hiz: assert property (@(posedge serial_bit_clock_i)
    disable iff (device_select_n_i)
    !hdr_r[HPSD_SER_RW_BIT] && bit_cnt_r >= HPSD_SER_DATA_START |=> !oe_r_r && !oe_f_r)
    else $error("serial out driven during write");
endmodule : hpsd_top

// *** verification/hpsd_host_model.sv ***
`timescale 1ns/1ps
// ****************
// host processor model
// ****************
module hpsd_host_model
  import hpsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic bus_oe_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  output logic cs_n_o,
  output logic fetch_n_o,
  output logic dir_o,
  output logic strobe_n_o,
  output logic ale_o,
  output logic as_n_o,
  output logic [4:0] addr_o,
  output logic [7:0] ad_o,
  output logic sclk_o,
  output logic sdi_o
);
  initial
  begin
    cs_n_o = 1'b1;
    fetch_n_o = 1'b1;
    dir_o = 1'b1;
    strobe_n_o = 1'b1;
    ale_o = 1'b0;
    as_n_o = 1'b1;
    addr_o = 5'h00;
    ad_o = 8'h00;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  task idle(input logic hw);
    @(posedge clk_i);
    fetch_n_o <= !hw;
    ale_o <= 1'b0;
  endtask : idle

  task par(input logic rd, input logic sep, input logic mux, input logic sel,
           input logic [4:0] a, input logic [7:0] d, input int wc,
           output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    cs_n_o <= !sel;
    addr_o <= a;
    dir_o <= rd;
    ad_o <= mux ? {3'h0, a} : d;
    if (mux)
    begin
      ale_o <= sep;
      as_n_o <= sep;
      repeat (5) @(posedge clk_i);
      ale_o <= 1'b0;
      as_n_o <= 1'b1;
    end
    repeat (5) @(posedge clk_i);
    ad_o <= rd ? ~ad_o : d;
    repeat (5) @(posedge clk_i);
    fetch_n_o <= !(rd && sep);
    strobe_n_o <= rd && sep;
    repeat (wc) @(posedge clk_i);
    q = bus_i;
    oe = bus_oe_i;
    fetch_n_o <= 1'b1;
    strobe_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    cs_n_o <= 1'b1;
    ad_o <= ~ad_o;
    repeat (6) @(posedge clk_i);
  endtask : par

  task ser(input logic rd, input logic [4:0] a, input logic [7:0] d,
           output logic [7:0] q, output logic oe_any);
    logic [15:0] f;
    f = {rd, a, 2'b00, d};
    q = 8'h00;
    oe_any = 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    #13;
    // msb first, bit clock only within frames
    for (int i = 15; i >= 0; i--)
    begin
      sdi_o = f[i];
      #40;
      oe_any |= sdo_oe_i;
      if (i < 8)
        q[i] = sdo_i;
      sclk_o = 1'b1;
      #40;
      sclk_o = 1'b0;
    end
    #20;
    sdi_o = ~sdi_o;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : ser
endmodule : hpsd_host_model

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`define HPSD_CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end
module testbench
  import hpsd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0] raw = 2'h0;
  logic [10:0] st = 11'h089;
  int mismatches = 0, checks = 0, cycles = 0;
  wire logic host_mode_i, serial_mode_i, cdr_mode_i, unipolar_i, bus_mux_select_i;
  wire logic bus_style_select_i, line_code_select_i, driver_output_enable_i;
  wire logic recovered_edge_select_i, jitter_path_select_i, jitter_path_open_i;
  wire logic device_select_n_i, fetch_enable_i, direction_select_i, transfer_strobe_i;
  wire logic addr_latch_strobe_i, addr_strobe_low_n_i, serial_bit_clock_i, serial_in_line_i;
  wire logic [4:0] addr_i;
  wire logic [7:0] ad_i, ad_o, host_ad, tx_hiz_o;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o, ad_oe_o, serial_out_line_o, serial_out_oe_o, rx_positive_rail_o;
  wire logic rx_negative_rail_o, ja_tx_path_o, ja_rx_path_o, hdb3_en_o, ami_en_o;
  wire logic rail_on_fall_o, sdo_on_rise_o;
  assign {host_mode_i, serial_mode_i, cdr_mode_i, unipolar_i, bus_mux_select_i,
    bus_style_select_i, line_code_select_i, driver_output_enable_i,
    recovered_edge_select_i, jitter_path_select_i, jitter_path_open_i} = st;
  assign ad_i = ad_oe_o ? ad_o : host_ad;

  hpsd_top DUT (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .host_mode_i, .serial_mode_i,
    .cdr_mode_i, .unipolar_i, .device_select_n_i, .fetch_enable_i, .direction_select_i,
    .transfer_strobe_i, .addr_latch_strobe_i, .addr_strobe_low_n_i, .bus_mux_select_i,
    .bus_style_select_i, .line_code_select_i, .driver_output_enable_i,
    .recovered_edge_select_i, .jitter_path_select_i, .jitter_path_open_i, .addr_i, .ad_i,
    .ad_o, .ad_oe_o, .serial_bit_clock_i, .serial_in_line_i, .serial_out_line_o,
    .serial_out_oe_o, .rx_pos_raw_i(raw[1]), .rx_neg_raw_i(raw[0]), .rx_positive_rail_o,
    .rx_negative_rail_o, .ja_tx_path_o, .ja_rx_path_o, .hdb3_en_o, .ami_en_o, .tx_hiz_o,
    .rail_on_fall_o, .sdo_on_rise_o);

  hpsd_host_model HOST (.clk_i, .bus_i(ad_i), .bus_oe_i(ad_oe_o), .sdo_i(serial_out_line_o),
    .sdo_oe_i(serial_out_oe_o), .cs_n_o(device_select_n_i), .fetch_n_o(fetch_enable_i),
    .dir_o(direction_select_i), .strobe_n_o(transfer_strobe_i), .ale_o(addr_latch_strobe_i),
    .as_n_o(addr_strobe_low_n_i), .addr_o(addr_i), .ad_o(host_ad),
    .sclk_o(serial_bit_clock_i), .sdi_o(serial_in_line_i));

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ****************
  // expectations and bus tasks
  // ****************
  function automatic logic [7:0] f_stat(input logic [10:0] v);
    return {v[3], v[2], v[8], v[7], v[5], v[6], v[9], v[10]};
  endfunction : f_stat

  function automatic logic [1:0] f_rail(input logic [10:0] v, input logic [1:0] r);
    return r ^ {2{!v[8] && !v[2]}};
  endfunction : f_rail

  function automatic logic [7:0] f_hiz(input logic [10:0] v, input logic [7:0] odis);
    return !v[3] ? 8'hFF : (v[10] ? odis : 8'h00);
  endfunction : f_hiz

  task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task set_st(input logic [10:0] v);
    HOST.idle(!v[10]);
    st <= v;
    raw <= 2'($urandom);
    repeat (6) @(posedge clk_i);
  endtask : set_st

  task end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // ****************
  // tests
  // ****************
  initial
  begin
    logic [31:0] d;
    logic [10:0] v;
    logic [10:0] corner [4];
    logic [7:0] q, dd;
    logic [4:0] a;
    logic oe;
    corner = '{11'h089, 11'h194, 11'h08A, 11'h10A};
    d = $urandom(32'h9397c07d);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, HPSD_WB_CTRL, 32'h0, d);
    `HPSD_CHK(d[0], HPSD_CTRL_RST)
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, d);
    wb(1'b0, 8'h10, 32'h0, d);
    `HPSD_CHK(d, 32'h0)
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      v = (i < 4) ? corner[i] : 11'($urandom);
      set_st(v);
      wb(1'b0, HPSD_WB_STAT, 32'h0, d);
      `HPSD_CHK(d[7:0], f_stat(v))
      if (!v[10])
      begin
        `HPSD_CHK({ja_tx_path_o, ja_rx_path_o}, v[0] ? 2'b00 : {!v[1], v[1]})
        `HPSD_CHK(tx_hiz_o, f_hiz(v, 8'h00))
      end
      if (!v[10] && v[7])
        `HPSD_CHK({hdb3_en_o, ami_en_o}, {!v[4], v[4]})
      if (v[8])
        `HPSD_CHK({rail_on_fall_o, sdo_on_rise_o}, {v[2], v[2]})
      `HPSD_CHK({rx_positive_rail_o, rx_negative_rail_o}, f_rail(v, raw))
    end
    $display("test straps done");
    for (int k = 0; k < 4; k++)
    begin
      set_st({4'b1010, k[1], k[0], 5'b01100});
      a = 5'($urandom);
      dd = 8'($urandom);
      HOST.par(1'b0, k[0], k[1], 1'b1, a, dd, 8 + $urandom % 12, q, oe);
      wb(1'b0, HPSD_WB_LAST, 32'h0, d);
      `HPSD_CHK(d[13:0], {1'b0, a, dd})
      HOST.par(1'b0, k[0], k[1], 1'b0, a, ~dd, 8, q, oe);
      HOST.par(1'b1, k[0], k[1], 1'b0, a, 8'h00, 8, q, oe);
      `HPSD_CHK(oe, 1'b0)
      HOST.par(1'b1, k[0], k[1], 1'b1, a, 8'h00, 8 + $urandom % 12, q, oe);
      `HPSD_CHK({oe, q}, {1'b1, dd})
      `HPSD_CHK(ad_oe_o, 1'b0)
    end
    $display("test parallel done");
    set_st(11'h50C);
    dd = 8'($urandom);
    HOST.par(1'b0, 1'b1, 1'b0, 1'b1, HPSD_ODIS_ADDR, dd, 10, q, oe);
    wb(1'b0, HPSD_WB_ODIS, 32'h0, d);
    `HPSD_CHK(d[7:0], dd)
    `HPSD_CHK(tx_hiz_o, f_hiz(11'h50C, dd))
    // host port switched off: a selected write must not land
    wb(1'b1, HPSD_WB_CTRL, 32'h0, d);
    HOST.par(1'b0, 1'b1, 1'b0, 1'b1, HPSD_ODIS_ADDR, ~dd, 10, q, oe);
    wb(1'b1, HPSD_WB_CTRL, 32'h1, d);
    wb(1'b0, HPSD_WB_ODIS, 32'h0, d);
    `HPSD_CHK(d[7:0], dd)
    set_st(11'h504);
    `HPSD_CHK(tx_hiz_o, 8'hFF)
    $display("test output disable done");
    set_st(11'h70C);
    for (int k = 0; k < 4; k++)
    begin
      // later frames use the opposite output edge
      if (k == 2)
        set_st(11'h708);
      a = 5'($urandom);
      dd = (k == 0) ? 8'hA5 : 8'($urandom);
      HOST.ser(1'b0, a, dd, q, oe);
      `HPSD_CHK(oe, 1'b0)
      wb(1'b0, HPSD_WB_LAST, 32'h0, d);
      `HPSD_CHK(d[13:0], {1'b1, a, dd})
      HOST.ser(1'b1, a, 8'h00, q, oe);
      `HPSD_CHK({oe, q}, {1'b1, dd})
      `HPSD_CHK(serial_out_oe_o, 1'b0)
    end
    $display("test serial done");
    end_sim();
  end
endmodule : testbench
